/* src/pemb_defines.svh */
// Constants of the paged external memory bus controller
`ifndef PEMB_DEFINES_SVH
`define PEMB_DEFINES_SVH

// ==============================
// Address control register layout
`define PEMB_ACR_PAGE_EN_BIT   7
`define PEMB_ACR_SEL_HI_BIT    1
`define PEMB_ACR_SEL_LO_BIT    0
`define PEMB_ACR_RESET         8'h00
`define PEMB_ACR_WR_MASK       8'h83

// ==============================
// Page select encodings
`define PEMB_SEL_ONE_CLK       2'h0
`define PEMB_SEL_TWO_CLK       2'h1
`define PEMB_SEL_FOUR_CLK      2'h2
`define PEMB_SEL_STRUCT2       2'h3

// ==============================
// Cycle lengths in system clocks
`define PEMB_HIT_LEN_SEL0      3'h1
`define PEMB_HIT_LEN_SEL1      3'h2
`define PEMB_HIT_LEN_SEL2      3'h4
`define PEMB_HIT_LEN_STRUCT2   3'h2
`define PEMB_CLASSIC_ADDR_LEN  3'h2
`define PEMB_CLASSIC_XFER_LEN  3'h2

`endif

/* src/pemb_pkg.sv */
// Types of the paged external memory bus controller
package pemb_pkg;
  typedef enum logic [1:0] {
    PEMB_IDLE = 2'b00,
    PEMB_ADDR = 2'b01,
    PEMB_XFER = 2'b10
  } pemb_phase_e;

  typedef enum logic [1:0] {
    PEMB_FETCH = 2'b00,
    PEMB_READ  = 2'b01,
    PEMB_WRITE = 2'b10
  } pemb_kind_e;
endpackage

/* src/pemb_bus.sv */
// Paged external memory bus controller: cycle sequencer, page tracking and pin drive
// Function
// R1: Page mode enable one selects paged bus; zero selects classic multiplexed bus.
// R2: Address control register accepts writes only while timed access is open.
// R3: Selects 00, 01, 10 use structure one; hit/miss 1/2, 2/4, 4/8 clocks.
// R4: Select 11 uses structure two; code fetch 2 clocks hit, 4 clocks miss.
// R5: Structure one: high port carries both address bytes, low port carries data.
// R6: Structure one fetch: low port floats, opcode latched at strobe rising edge.
// R7: Structure one data: low port floats on reads, drives write data on writes.
// R8: Upper address byte differing from previous external access is a page miss.
// R9: Upper address byte equal to previous external access is a page hit.
// R10: Structure one hit drives lower byte on high port, no address latch strobe.
// R11: On hit the fetch, read or write strobe pulses; transfer on low port.
// R12: Miss drives upper byte on high port first half with latch strobe.
// R13: Miss first half keeps all strobes inactive and low port floating.
// R14: Miss second half runs exactly like a hit cycle.
// R15: Upper byte stored for comparison; first external access is a miss.
// R16: Select 00 fetch strobe lasts full clock, stays active over back-to-back hits.
// R17: Select 00 forces a miss for every external data move.
// R18: Select 00 forces a miss on the fetch after an external data move.
// R19: Select 01 holds fetch strobe active one full clock in code fetches.
// R20: Data hit compare uses last external address, fetches included.
// R21: Structure two: upper byte multiplexed with data on high port, lower byte on low.
// R22: Structure two data accesses use four-clock classic form, hit or miss.
// R23: Classic external cycle lasts four clocks.
// R24: External latch captures upper byte on latch strobe, holds until next miss.
`include "pemb_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module pemb_bus
  import pemb_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Address control register write port
  input  wire logic        cfgWrStb,
  input  wire logic [7:0]  cfgWrData,
  input  wire logic        timedAccessOpen,
  output logic             pageModeEnable,
  output logic [1:0]       pageSelect,
  // Access request and answer
  input  wire logic        reqValid,
  input  wire logic [1:0]  reqKind,
  input  wire logic [15:0] reqAddr,
  input  wire logic [7:0]  reqWrData,
  output logic             reqReady,
  output logic             rspValid,
  output logic [7:0]       rspData,
  output logic             pageMissOut,
  // External bus pins
  input  wire logic [7:0]  lowBusPortIn,
  output logic [7:0]       lowBusPortOut,
  output logic             lowBusPortOe,
  input  wire logic [7:0]  highBusPortIn,
  output logic [7:0]       highBusPortOut,
  output logic             highBusPortOe,
  output logic             addrLatchStrobe,
  output logic             programFetchStrobeN,
  output logic             readStrobeN,
  output logic             writeStrobeN
);

  // ==============================
  // Address control register
  logic [7:0] acr_q;
  logic       acrWrite;
  assign acrWrite       = cfgWrStb && timedAccessOpen; // R2
  assign pageModeEnable = acr_q[`PEMB_ACR_PAGE_EN_BIT];
  assign pageSelect     = {acr_q[`PEMB_ACR_SEL_HI_BIT], acr_q[`PEMB_ACR_SEL_LO_BIT]};

  // Register write, gated by the timed access window
  always_ff @(posedge mclk) begin
    if (rst) begin
      acr_q <= `PEMB_ACR_RESET;
    end else if (acrWrite) begin
      acr_q <= cfgWrData & `PEMB_ACR_WR_MASK; // R2
    end
  end

  // ==============================
  // Pin input synchronisers
  logic [7:0] lowSync1_q, lowSync2_q, highSync1_q, highSync2_q;
  always_ff @(posedge mclk) begin
    lowSync1_q  <= lowBusPortIn;
    lowSync2_q  <= lowSync1_q;
    highSync1_q <= highBusPortIn;
    highSync2_q <= highSync1_q;
  end

  // ==============================
  // Sequencer state
  pemb_phase_e phase_q;
  logic [2:0]  cnt_q;
  logic [1:0]  kind_q;
  logic [15:0] addr_q;
  logic [7:0]  wdat_q;
  logic        struct2_q, classic_q, sel01_q, miss_q;
  logic [2:0]  xferLen_q;
  logic [7:0]  lastUpper_q;
  logic        lastValid_q, afterMove_q;

  // Request decode and mode selection
  logic       lastClk, accept, isFetch, paged, struct2, classic, missNow;
  logic [2:0] hitLen, addrLen, xferLen;
  assign lastClk  = (phase_q == PEMB_XFER) && (cnt_q == 3'h0);
  assign reqReady = (phase_q == PEMB_IDLE) || lastClk;
  assign accept   = reqValid && reqReady;
  assign isFetch  = (reqKind == PEMB_FETCH);
  assign paged    = pageModeEnable; // R1
  assign struct2  = paged && (pageSelect == `PEMB_SEL_STRUCT2); // R4
  assign classic  = !paged || (struct2 && !isFetch); // R1 R22
  assign hitLen   = (pageSelect == `PEMB_SEL_ONE_CLK)  ? `PEMB_HIT_LEN_SEL0 :
                    (pageSelect == `PEMB_SEL_TWO_CLK)  ? `PEMB_HIT_LEN_SEL1 :
                    (pageSelect == `PEMB_SEL_FOUR_CLK) ? `PEMB_HIT_LEN_SEL2 :
                                                         `PEMB_HIT_LEN_STRUCT2; // R3 R4
  // Miss when upper byte changes, on the first access, or when select 00 forces it
  assign missNow  = !lastValid_q || (reqAddr[15:8] != lastUpper_q) // R8 R9 R15 R20
                    || ((pageSelect == `PEMB_SEL_ONE_CLK) && !isFetch) // R17
                    || ((pageSelect == `PEMB_SEL_ONE_CLK) && afterMove_q); // R18
  assign addrLen  = classic ? `PEMB_CLASSIC_ADDR_LEN : (missNow ? hitLen : 3'h0); // R14 R23
  assign xferLen  = classic ? `PEMB_CLASSIC_XFER_LEN : hitLen; // R22 R23

  // Phase and counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_q <= PEMB_IDLE;
      cnt_q   <= 3'h0;
    end else if (accept) begin
      phase_q <= (addrLen != 3'h0) ? PEMB_ADDR : PEMB_XFER;
      cnt_q   <= (addrLen != 3'h0) ? addrLen - 3'h1 : xferLen - 3'h1;
    end else if (phase_q == PEMB_ADDR && cnt_q == 3'h0) begin
      phase_q <= PEMB_XFER; // R14
      cnt_q   <= xferLen_q - 3'h1;
    end else if (lastClk) begin
      phase_q <= PEMB_IDLE;
    end else if (phase_q != PEMB_IDLE) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // Access fields latched at acceptance
  always_ff @(posedge mclk) begin
    if (rst) begin
      kind_q    <= PEMB_FETCH;
      addr_q    <= 16'h0000;
      wdat_q    <= 8'h00;
      struct2_q <= 1'b0;
      classic_q <= 1'b1;
      sel01_q   <= 1'b0;
      miss_q    <= 1'b0;
      xferLen_q <= `PEMB_CLASSIC_XFER_LEN;
    end else if (accept) begin
      kind_q    <= reqKind;
      addr_q    <= reqAddr;
      wdat_q    <= reqWrData;
      struct2_q <= struct2;
      classic_q <= classic;
      sel01_q   <= paged && (pageSelect == `PEMB_SEL_TWO_CLK);
      miss_q    <= missNow;
      xferLen_q <= xferLen;
    end
  end

  // Page tracking: last upper byte of any external access
  always_ff @(posedge mclk) begin
    if (rst) begin
      lastUpper_q <= 8'h00;
      lastValid_q <= 1'b0; // R15
      afterMove_q <= 1'b0;
    end else if (accept) begin
      lastUpper_q <= reqAddr[15:8]; // R15 R20
      lastValid_q <= 1'b1;
      afterMove_q <= !isFetch; // R18
    end
  end
  assign pageMissOut = miss_q;

  // ==============================
  // Pin drive
  logic inAddr, inXfer, isWr, fetchQ, strobeWin;
  assign inAddr    = (phase_q == PEMB_ADDR);
  assign inXfer    = (phase_q == PEMB_XFER);
  assign isWr      = (kind_q == PEMB_WRITE);
  assign fetchQ    = (kind_q == PEMB_FETCH);
  // Select 01 fetch strobe covers the last full clock only
  assign strobeWin = inXfer && (!(sel01_q && fetchQ) || cnt_q == 3'h0); // R16 R19

  assign addrLatchStrobe     = inAddr; // R10 R12
  assign programFetchStrobeN = !(strobeWin && fetchQ); // R11 R13 R16
  assign readStrobeN         = !(strobeWin && kind_q == PEMB_READ); // R11 R13
  assign writeStrobeN        = !(strobeWin && isWr); // R11 R13

  // High port: upper byte in address phase and classic transfer, write data on structure two, else lower byte
  assign highBusPortOut = (inAddr || (classic_q && !struct2_q)) ? addr_q[15:8] :
                          struct2_q ? wdat_q : addr_q[7:0]; // R5 R10 R12 R21
  // Structure two releases the high port for reads and fetches so memory can answer on it
  assign highBusPortOe  = inAddr || (inXfer && (!struct2_q || isWr)); // R21
  // Low port: lower byte on structure two and in the classic address phase, write data otherwise
  assign lowBusPortOut  = (struct2_q || (classic_q && inAddr)) ? addr_q[7:0] : wdat_q; // R7 R21
  assign lowBusPortOe   = struct2_q ? (inAddr || inXfer) :
                          classic_q ? (inAddr || (inXfer && isWr)) :
                                      (inXfer && isWr); // R6 R7 R13

  // ==============================
  // Read data capture, delayed to match the synchronisers
  logic       endRead, fromHigh;
  logic [1:0] capDly_q, srcDly_q, doneDly_q;
  assign endRead  = lastClk && !isWr; // R6
  assign fromHigh = struct2_q; // R21

  always_ff @(posedge mclk) begin
    if (rst) begin
      capDly_q  <= 2'h0;
      srcDly_q  <= 2'h0;
      doneDly_q <= 2'h0;
      rspValid  <= 1'b0;
      rspData   <= 8'h00;
    end else begin
      capDly_q  <= {capDly_q[0], endRead};
      srcDly_q  <= {srcDly_q[0], fromHigh};
      doneDly_q <= {doneDly_q[0], lastClk};
      rspValid  <= doneDly_q[1];
      if (capDly_q[1]) begin
        rspData <= srcDly_q[1] ? highSync2_q : lowSync2_q; // R6 R21
      end
    end
  end

  // ==============================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_hit_no_latch; // R10
    accept && paged && !struct2 && !missNow |=> inXfer && !addrLatchStrobe && highBusPortOut == $past(reqAddr[7:0]);
  endproperty
  a_hit_no_latch: assert property (p_hit_no_latch) else $error("hit raised latch strobe or wrong byte");

  property p_miss_upper; // R12
    accept && paged && !struct2 && missNow |=> addrLatchStrobe && highBusPortOut == $past(reqAddr[15:8]);
  endproperty
  a_miss_upper: assert property (p_miss_upper) else $error("miss did not present upper byte");

  property p_addr_quiet; // R13
    inAddr && !classic_q |-> programFetchStrobeN && readStrobeN && writeStrobeN && (struct2_q || !lowBusPortOe);
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("strobe or low port active in address half");

  property p_first_miss; // R15
    accept && !lastValid_q |-> missNow;
  endproperty
  a_first_miss: assert property (p_first_miss) else $error("first access not a miss");

  property p_sel0_move_miss; // R17
    accept && paged && pageSelect == `PEMB_SEL_ONE_CLK && !isFetch |=> addrLatchStrobe;
  endproperty
  a_sel0_move_miss: assert property (p_sel0_move_miss) else $error("data move under select 00 was a hit");

  property p_sel1_hit_len; // R3
    accept && paged && pageSelect == `PEMB_SEL_TWO_CLK && !missNow
      |=> (inXfer && cnt_q == 3'h1) ##1 lastClk;
  endproperty
  a_sel1_hit_len: assert property (p_sel1_hit_len) else $error("select 01 hit not two clocks");

  property p_classic_len; // R23
    accept && !paged |=> addrLatchStrobe [*2] ##1 (inXfer && !addrLatchStrobe) [*2];
  endproperty
  a_classic_len: assert property (p_classic_len) else $error("classic cycle not four clocks");

  property p_locked_acr; // R2
    cfgWrStb && !timedAccessOpen |=> acr_q == $past(acr_q);
  endproperty
  a_locked_acr: assert property (p_locked_acr) else $error("register changed without timed access");

  property p_fetch_float; // R6
    inXfer && fetchQ && !classic_q && !struct2_q |-> !lowBusPortOe && !programFetchStrobeN == strobeWin;
  endproperty
  a_fetch_float: assert property (p_fetch_float) else $error("low port driven during fetch");

  property p_struct2_fetch; // R21
    inXfer && struct2_q && fetchQ |-> !highBusPortOe && lowBusPortOe && lowBusPortOut == addr_q[7:0];
  endproperty
  a_struct2_fetch: assert property (p_struct2_fetch) else $error("structure two fetch pins wrong");

endmodule // pemb_bus

`default_nettype wire

/* bench/pemb_mem_model.sv */
// External memory with an upper address latch, seen from the bus pins
`timescale 1ns/1ns
`default_nettype none

module pemb_mem_model (
  // Clock
  input  wire logic       mclk,
  // Strobes and bus form
  input  wire logic       ale,
  input  wire logic       fetchN,
  input  wire logic       readN,
  input  wire logic       writeN,
  input  wire logic       structOne,
  input  wire logic       structTwo,
  // Resolved port levels and memory drive
  input  wire logic [7:0] lowPin,
  input  wire logic [7:0] highPin,
  output logic [7:0]      dataOut
);
  logic [7:0] upperQ = 8'h00, lowerQ = 8'h00, dataQ = 8'h00;
  logic [1:0] holdQ = 2'h0;
  logic [7:0] mem [0:65535];
  // Lower byte comes live off the pins in structure one and in structure two fetches, else from the latched address phase
  wire [7:0] lower = structOne ? highPin : ((structTwo && !fetchN) ? lowPin : lowerQ);
  wire [15:0] addr = {upperQ, lower};
  wire rdLow = !fetchN || !readN;
  // Memory drives while the fetch or read strobe is low and two clocks on, then an inverted pattern
  assign dataOut = rdLow ? mem[addr] : ((holdQ != 2'h0) ? dataQ : ~dataQ);
  // Contents start as a pattern of the address
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[15:8] ^ i[7:0] ^ 8'h3C;
    end
  end
  // Address latch, read hold and write capture
  always @(posedge mclk) begin
    if (ale) begin
      upperQ <= highPin;
      lowerQ <= lowPin;
    end
    if (rdLow) begin
      dataQ <= mem[addr];
      holdQ <= 2'h2;
    end else if (holdQ != 2'h0) begin
      holdQ <= holdQ - 2'h1;
    end
    if (!writeN) begin
      mem[addr] <= structTwo ? highPin : lowPin;
    end
  end
endmodule // pemb_mem_model

`default_nettype wire

/* bench/tb.sv */
// Self-checking bench of the paged external memory bus controller
`include "pemb_defines.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module tb;
  import pemb_pkg::*;
  // ==============================
  // Stimulus, design outputs and expectation queues
  logic        mclk = 1'b0, rst = 1'b1, cfgWrStb = 1'b0, timedAccessOpen = 1'b0, reqValid = 1'b0;
  logic [7:0]  cfgWrData = 8'h00, reqWrData = 8'h00, cfg = 8'h00, lastUpper = 8'h00, dNow;
  logic [1:0]  reqKind = 2'h0, pageSelect;
  logic [15:0] reqAddr = 16'h0000, base;
  logic [7:0]  rspData, lowBusPortOut, highBusPortOut, memData;
  logic        reqReady, rspValid, pageMissOut, lowBusPortOe, highBusPortOe, addrLatchStrobe;
  logic        programFetchStrobeN, readStrobeN, writeStrobeN, pageModeEnable;
  logic        first = 1'b1, prevData = 1'b0, skipMiss = 1'b1;
  logic [2:0]  fNow;
  int          n_fail = 0, compares = 0, cyc = 0, seed = 15;
  int          qCyc[$];
  logic [7:0]  qData[$];
  logic [2:0]  qFlag[$];
  logic [7:0]  wmem[int];
  wire         s1 = cfg[7] && (cfg[1:0] != 2'h3);
  wire         s2 = cfg[7] && (cfg[1:0] == 2'h3);
  wire [7:0]   lowIn = lowBusPortOe ? lowBusPortOut : memData;
  wire [7:0]   highIn = highBusPortOe ? highBusPortOut : memData;

  // Clock and cycle count
  always #4 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  pemb_bus uut (.mclk(mclk), .rst(rst), .cfgWrStb(cfgWrStb), .cfgWrData(cfgWrData),
    .timedAccessOpen(timedAccessOpen), .pageModeEnable(pageModeEnable), .pageSelect(pageSelect),
    .reqValid(reqValid), .reqKind(reqKind), .reqAddr(reqAddr), .reqWrData(reqWrData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .pageMissOut(pageMissOut),
    .lowBusPortIn(lowIn), .lowBusPortOut(lowBusPortOut), .lowBusPortOe(lowBusPortOe),
    .highBusPortIn(highIn), .highBusPortOut(highBusPortOut), .highBusPortOe(highBusPortOe),
    .addrLatchStrobe(addrLatchStrobe), .programFetchStrobeN(programFetchStrobeN),
    .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN));

  pemb_mem_model mem (.mclk(mclk), .ale(addrLatchStrobe), .fetchN(programFetchStrobeN),
    .readN(readStrobeN), .writeN(writeStrobeN), .structOne(s1), .structTwo(s2),
    .lowPin(lowIn), .highPin(highIn), .dataOut(memData));

  // ==============================
  // Verdict
  task automatic report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Control register write, entered and left at a falling edge
  task automatic setCfg(input logic open, input logic [7:0] d);
    cfgWrData = d;
    timedAccessOpen = open;
    cfgWrStb = 1'b1;
    @(negedge mclk);
    cfgWrStb = 1'b0;
    timedAccessOpen = 1'b0;
    if (open) cfg = d & `PEMB_ACR_WR_MASK;
    skipMiss = 1'b1;
    @(negedge mclk);
    `CHK("pageModeEnable", cfg[7], pageModeEnable);
    `CHK("pageSelect", cfg[1:0], pageSelect);
  endtask

  // One access: hold the request until taken, then note the expected answer
  task automatic acc(input logic [1:0] k, input logic [15:0] a, input logic [7:0] wd);
    int len, h, n;
    logic miss, dat;
    dat = (k != PEMB_FETCH);
    miss = first || (a[15:8] != lastUpper) || (cfg[1:0] == 2'h0 && (dat || prevData));
    h = (cfg[1:0] == 2'h0) ? 1 : (cfg[1:0] == 2'h2) ? 4 : 2;
    len = (!cfg[7] || (s2 && dat)) ? 4 : (miss ? 2 * h : h);
    reqKind = k;
    reqAddr = a;
    reqWrData = wd;
    reqValid = 1'b1;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    `CHK("reqReady", 1'b1, reqReady);
    @(posedge mclk);
    @(negedge mclk);
    qCyc.push_back(cyc + len + 2);
    qData.push_back(wmem.exists(a) ? wmem[a] : (a[15:8] ^ a[7:0] ^ 8'h3C));
    qFlag.push_back({miss, cfg[7] && !(s2 && dat) && !skipMiss, k != PEMB_WRITE});
    // Miss flag shows the access just taken, so look before a back-to-back request replaces it
    if (cfg[7] && !(s2 && dat) && !skipMiss) `CHK("pageMissOut", miss, pageMissOut);
    if (k == PEMB_WRITE) wmem[a] = wd;
    lastUpper = a[15:8];
    first = 1'b0;
    prevData = dat;
    skipMiss = 1'b0;
  endtask

  // Answer and pin watcher
  always @(negedge mclk) begin
    if (rspValid === 1'b1) begin
      if (qCyc.size() != 0) begin
        `CHK("rspCycle", qCyc.pop_front(), cyc);
        fNow = qFlag.pop_front();
        dNow = qData.pop_front();
        if (fNow[0]) `CHK("rspData", dNow, rspData);
      end else `CHK("rspValid", 1'b0, rspValid);
    end
    if (s1 && addrLatchStrobe === 1'b1) `CHK("missHalf", 4'h7, {lowBusPortOe, programFetchStrobeN, readStrobeN, writeStrobeN});
    if (s1 && (programFetchStrobeN === 1'b0 || readStrobeN === 1'b0)) `CHK("lowOeRead", 1'b0, lowBusPortOe);
    if (s1 && writeStrobeN === 1'b0) `CHK("lowOeWrite", 1'b1, lowBusPortOe);
  end

  // Watchdog
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end

  // ==============================
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    `CHK("idlePins", 5'h07, {lowBusPortOe, highBusPortOe, programFetchStrobeN, readStrobeN, writeStrobeN});
    `CHK("rspData", 8'h00, rspData);
    setCfg(1'b0, 8'hFF);
    for (int m = 0; m < 5; m++) begin
      setCfg(1'b1, (m == 0) ? 8'h7C : (8'hFC | 8'(m - 1)));
      base = 16'($random(seed));
      acc(PEMB_WRITE, base, 8'($random(seed)));
      acc(PEMB_READ, base, 8'h00);
      acc(PEMB_FETCH, {base[15:8], base[7:0] ^ 8'h01}, 8'h00);
      acc(PEMB_FETCH, {base[15:8], ~base[7:0]}, 8'h00);
      acc(PEMB_READ, {base[15:8] ^ 8'h01, base[7:0]}, 8'h00);
      acc(PEMB_FETCH, {base[15:8] ^ 8'h01, 8'h10}, 8'h00);
      reqValid = 1'b0;
      repeat (14) @(negedge mclk);
    end
    `CHK("pending", 0, qCyc.size());
    report_and_stop;
  end
endmodule // tb

`default_nettype wire
